// ===== hdl/core_mem_pkg.sv
/*
 Shared constants, types and decode helpers for the core memory bank port.
 Assumes a single 100 MHz system clock; all widths are fixed.
*/
package core_mem_pkg;

   // Word and storage geometry
   localparam int WORD_BITS = 18;
   localparam int STORE_BITS = 19;
   localparam int ADDR_BITS = 18;
   localparam int PAGE_WORDS = 4096;
   localparam int BANK_WORDS = 8192;
   localparam int BANK_ADDR_BITS = 13;
   localparam int BANK_SEL_BITS = 4;
   localparam int MAX_BANKS = 16;
   localparam int FITTED_BANKS = 4;
   localparam int FITTED_SEL_BITS = 2;
   localparam int SPACE_WORDS = 131072;
   localparam int BLOCK_WORDS = 32768;

   // Address fields; bit 0 of the machine's numbering is the MSB here
   localparam int SIGN_POS = 17;
   localparam int BANK_HI = 16;
   localparam int BANK_LO = 13;
   localparam int PAGE_POS = 12;
   localparam int ROW_HI = 11;
   localparam int ROW_LO = 6;
   localparam int COL_HI = 5;
   localparam int COL_LO = 0;
   localparam int PARITY_POS = 18;

   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int ACCESS_NS = 400;
   localparam int PLAIN_CYCLE_NS = 800;
   localparam int PARITY_CYCLE_NS = 1100;
   localparam int CNT_BITS = 7;
   localparam int ACCESS_CYCLES = ACCESS_NS / CLK_PERIOD_NS;
   localparam int PLAIN_CYCLES = PLAIN_CYCLE_NS / CLK_PERIOD_NS;
   localparam int PARITY_CYCLES = PARITY_CYCLE_NS / CLK_PERIOD_NS;
   localparam logic [CNT_BITS-1:0] ACCESS_LAST = CNT_BITS'(ACCESS_CYCLES - 1);
   localparam logic [CNT_BITS-1:0] PLAIN_LAST = CNT_BITS'(PLAIN_CYCLES - 1);
   localparam logic [CNT_BITS-1:0] PARITY_LAST = CNT_BITS'(PARITY_CYCLES - 1);
   localparam logic [CNT_BITS-1:0] CNT_ZERO = 7'h00;
   localparam logic [CNT_BITS-1:0] CNT_ONE = 7'h01;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACCESS = 2'b01,
      ST_RESTORE = 2'b10,
      ST_TRAP = 2'b11
   } cycle_state_t;

   typedef enum logic {
      OWNER_CPU = 1'b0,
      OWNER_IO = 1'b1
   } owner_t;

   function automatic logic [BANK_SEL_BITS-1:0] bank_field(input logic [ADDR_BITS-1:0] addr);
      return addr[BANK_HI:BANK_LO];
   endfunction

   // Base setting counts in whole banks, so the sum wraps over all sixteen
   function automatic logic [BANK_SEL_BITS-1:0] relocate(
      input logic [BANK_SEL_BITS-1:0] bank,
      input logic [BANK_SEL_BITS-1:0] base);
      return BANK_SEL_BITS'(bank + base);
   endfunction

   function automatic logic bank_fitted(input logic [BANK_SEL_BITS-1:0] bank);
      return bank < BANK_SEL_BITS'(FITTED_BANKS);
   endfunction

endpackage

// ===== hdl/odd_parity_gen.sv
/*
 Odd parity generator for one data word.
 Purely combinational; the caller registers the result.
*/
`timescale 1ns/10ps
module odd_parity_gen (
   input wire logic [core_mem_pkg::WORD_BITS-1:0] data,
   output logic parity_bit
);
   import core_mem_pkg::*;

   // One when the data holds an even count of ones, so the total is odd
   assign parity_bit = ~^data;

endmodule // odd_parity_gen

// ===== hdl/bank_array.sv
/*
 Storage array of one bank: two pages, 19 bits per location.
 Assumes one access per cycle and that the caller holds the address buffer.
*/
`timescale 1ns/10ps
module bank_array (
   input wire logic sys_clk,
   input wire logic write_en,
   input wire logic read_en,
   input wire logic [core_mem_pkg::BANK_ADDR_BITS-1:0] word_addr,
   input wire logic [core_mem_pkg::STORE_BITS-1:0] write_word,
   output logic [core_mem_pkg::STORE_BITS-1:0] read_word
);
   import core_mem_pkg::*;

   logic [STORE_BITS-1:0] cells [0:BANK_WORDS-1];

   // Whole word, parity included, moves at once
   always_ff @(posedge sys_clk) begin
      if (write_en) begin
         cells[word_addr] <= write_word;
      end
   end

   // Storage contents carry no reset, as core keeps no defined state
   always_ff @(posedge sys_clk) begin
      if (read_en) begin
         read_word <= cells[word_addr];
      end
   end

endmodule // bank_array

// ===== hdl/core_memory_bank_port.sv
/*
 Core memory subsystem: port switch for the central processor and the
 I/O processor, optional relocating multiplexer, four fitted banks,
 optional odd parity with an alarm, illegal address handling.
 Assumes each requester holds req, write, addr and wdata stable from
 raising req until its done or trap pulse, and lowers req after it.
*/
`timescale 1ns/10ps

module core_memory_bank_port (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic parity_fitted,
   input wire logic protect_fitted,
   input wire logic mux_fitted,
   input wire logic [core_mem_pkg::BANK_SEL_BITS-1:0] cpu_base_bank,
   input wire logic [core_mem_pkg::BANK_SEL_BITS-1:0] io_base_bank,
   input wire logic halt_on_parity,
   input wire logic use_priority_interrupt,
   input wire logic alarm_clear,
   input wire logic cpu_req,
   input wire logic cpu_write,
   input wire logic [core_mem_pkg::ADDR_BITS-1:0] cpu_addr,
   input wire logic [core_mem_pkg::WORD_BITS-1:0] cpu_wdata,
   output logic cpu_grant,
   output logic cpu_done,
   output logic cpu_trap,
   output logic [core_mem_pkg::WORD_BITS-1:0] cpu_rdata,
   input wire logic io_processor_req,
   input wire logic io_processor_write,
   input wire logic [core_mem_pkg::ADDR_BITS-1:0] io_processor_addr,
   input wire logic [core_mem_pkg::WORD_BITS-1:0] io_processor_wdata,
   output logic io_processor_grant,
   output logic io_processor_done,
   output logic io_processor_trap,
   output logic [core_mem_pkg::WORD_BITS-1:0] io_processor_rdata,
   output logic parity_error,
   output logic program_interrupt_request,
   output logic priority_interrupt_request,
   output logic halt_request
);
   import core_mem_pkg::*;

   cycle_state_t state;
   owner_t owner;
   logic [CNT_BITS-1:0] cnt;
   logic parity_on;
   logic [ADDR_BITS-1:0] addr_buf;
   logic [WORD_BITS-1:0] data_buf;
   logic write_buf;
   logic [BANK_SEL_BITS-1:0] phys_bank;

   // Port switch choice, looked at only while idle
   logic pick_io;
   logic pick_req;
   logic pick_write;
   logic [ADDR_BITS-1:0] pick_addr;
   logic [WORD_BITS-1:0] pick_wdata;
   logic [BANK_SEL_BITS-1:0] pick_base;
   logic [BANK_SEL_BITS-1:0] pick_bank;
   logic pick_legal;
   logic pick_present;
   logic start;
   logic trap;
   logic owner_req;

   logic access_edge;
   logic data_ready;
   logic cycle_end;
   logic [CNT_BITS-1:0] cycle_last;
   logic write_parity;
   logic check_parity;
   logic [STORE_BITS-1:0] store_word;
   logic [STORE_BITS-1:0] sel_word;
   logic mismatch;
   logic alarm;
   logic [STORE_BITS-1:0] bank_read [0:FITTED_BANKS-1];

   always_comb begin
      pick_io = io_processor_req;
      pick_req = io_processor_req | cpu_req;
      pick_write = io_processor_req ? io_processor_write : cpu_write;
      pick_addr = io_processor_req ? io_processor_addr : cpu_addr;
      pick_wdata = io_processor_req ? io_processor_wdata : cpu_wdata;
      if (mux_fitted) begin
         pick_base = io_processor_req ? io_base_bank : cpu_base_bank;
      end else begin
         pick_base = '0;
      end
      pick_bank = relocate(bank_field(pick_addr), pick_base);
      pick_legal = ~pick_addr[SIGN_POS];
      pick_present = bank_fitted(pick_bank);
      // A missing bank at a legal address, or an illegal address without protect fitted, never answers, so its requester hangs
      start = (state == ST_IDLE) && pick_req && pick_legal && pick_present;
      trap = (state == ST_IDLE) && pick_req && !pick_legal && protect_fitted;
   end

   assign owner_req = (owner == OWNER_IO) ? io_processor_req : cpu_req;
   assign access_edge = (state == ST_ACCESS) && (cnt == CNT_ZERO);
   assign data_ready = (state == ST_ACCESS) && (cnt == ACCESS_LAST);
   assign cycle_last = parity_on ? PARITY_LAST : PLAIN_LAST;
   assign cycle_end = (state == ST_RESTORE) && (cnt == cycle_last);

   // Cycle sequencer: one owner per cycle, others wait in idle
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         cnt <= CNT_ZERO;
      end else begin
         case (state)
            ST_IDLE: begin
               cnt <= CNT_ZERO;
               if (start) begin
                  state <= ST_ACCESS;
               end else if (trap) begin
                  state <= ST_TRAP;
               end
            end
            ST_ACCESS: begin
               cnt <= cnt + CNT_ONE;
               if (data_ready) begin
                  state <= ST_RESTORE;
               end
            end
            ST_RESTORE: begin
               cnt <= cnt + CNT_ONE;
               if (cycle_end) begin
                  state <= ST_IDLE;
               end
            end
            ST_TRAP: begin
               cnt <= CNT_ZERO;
               // Wait for the trapped requester to let go, so one trap per request
               if (!owner_req) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
               cnt <= CNT_ZERO;
            end
         endcase
      end
   end

   // Owner and parity option are frozen for the whole cycle
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         owner <= OWNER_CPU;
      end else if (start || trap) begin
         owner <= pick_io ? OWNER_IO : OWNER_CPU;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         parity_on <= 1'b0;
      end else if (start || trap) begin
         parity_on <= parity_fitted;
      end
   end

   // Address buffer latches the owner's request at grant
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         addr_buf <= '0;
         phys_bank <= '0;
      end else if (start) begin
         addr_buf <= pick_addr;
         phys_bank <= pick_bank;
      end
   end

   // Data buffer and direction, kept apart from addressing
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         data_buf <= '0;
         write_buf <= 1'b0;
      end else if (start) begin
         data_buf <= pick_wdata;
         write_buf <= pick_write;
      end
   end

   odd_parity_gen u_write_parity (
      .data(data_buf),
      .parity_bit(write_parity)
   );

   // Without parity the extra plane bit is written as zero and never read
   assign store_word = {parity_on & write_parity, data_buf};

   generate
      for (genvar b = 0; b < FITTED_BANKS; b++) begin : g_bank
         bank_array u_bank (
            .sys_clk(sys_clk),
            .write_en(access_edge && write_buf && (phys_bank == BANK_SEL_BITS'(b))),
            .read_en(access_edge && !write_buf && (phys_bank == BANK_SEL_BITS'(b))),
            .word_addr({addr_buf[PAGE_POS], addr_buf[ROW_HI:ROW_LO],
               addr_buf[COL_HI:COL_LO]}),
            .write_word(store_word),
            .read_word(bank_read[b])
         );
      end
   endgenerate

   assign sel_word = bank_read[phys_bank[FITTED_SEL_BITS-1:0]];

   odd_parity_gen u_read_parity (
      .data(sel_word[WORD_BITS-1:0]),
      .parity_bit(check_parity)
   );

   assign mismatch = check_parity != sel_word[PARITY_POS];
   assign alarm = data_ready && !write_buf && parity_on && mismatch;

   // Grant stands from acceptance to the end of the full cycle
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         cpu_grant <= 1'b0;
      end else if (start) begin
         cpu_grant <= !pick_io;
      end else if (cycle_end) begin
         cpu_grant <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         io_processor_grant <= 1'b0;
      end else if (start) begin
         io_processor_grant <= pick_io;
      end else if (cycle_end) begin
         io_processor_grant <= 1'b0;
      end
   end

   // Done marks read data valid, or the write stored
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         cpu_done <= 1'b0;
      end else begin
         cpu_done <= data_ready && (owner == OWNER_CPU);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         io_processor_done <= 1'b0;
      end else begin
         io_processor_done <= data_ready && (owner == OWNER_IO);
      end
   end

   // Full-width parallel word onto the bus; parity bit stays inside
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         cpu_rdata <= '0;
      end else if (data_ready && !write_buf && (owner == OWNER_CPU)) begin
         cpu_rdata <= sel_word[WORD_BITS-1:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         io_processor_rdata <= '0;
      end else if (data_ready && !write_buf && (owner == OWNER_IO)) begin
         io_processor_rdata <= sel_word[WORD_BITS-1:0];
      end
   end

   // Trap pulses last one cycle; the sequencer holds off a repeat
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         cpu_trap <= 1'b0;
      end else begin
         cpu_trap <= trap && !pick_io;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         io_processor_trap <= 1'b0;
      end else begin
         io_processor_trap <= trap && pick_io;
      end
   end

   // Alarm pulse follows the checked read and keeps no state
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         parity_error <= 1'b0;
      end else begin
         parity_error <= alarm;
      end
   end

   // Sticky routes; a new error in the clearing cycle keeps its flag set
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         program_interrupt_request <= 1'b0;
      end else if (alarm && !halt_on_parity && !use_priority_interrupt) begin
         program_interrupt_request <= 1'b1;
      end else if (alarm_clear) begin
         program_interrupt_request <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         priority_interrupt_request <= 1'b0;
      end else if (alarm && !halt_on_parity && use_priority_interrupt) begin
         priority_interrupt_request <= 1'b1;
      end else if (alarm_clear) begin
         priority_interrupt_request <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         halt_request <= 1'b0;
      end else if (alarm && halt_on_parity) begin
         halt_request <= 1'b1;
      end else if (alarm_clear) begin
         halt_request <= 1'b0;
      end
   end

endmodule // core_memory_bank_port

// ===== test/core_memory_bank_port_props.sv
/*
 Checker for the memory port switch, bound to the top module.
 Assumes one clock domain and the synchronous active-low reset.
*/
`timescale 1ns/10ps
module core_memory_bank_port_props (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic parity_fitted,
   input wire logic protect_fitted,
   input wire logic halt_on_parity,
   input wire logic use_priority_interrupt,
   input wire logic alarm_clear,
   input wire logic cpu_req,
   input wire logic [core_mem_pkg::ADDR_BITS-1:0] cpu_addr,
   input wire logic cpu_grant,
   input wire logic cpu_done,
   input wire logic cpu_trap,
   input wire logic io_processor_req,
   input wire logic [core_mem_pkg::ADDR_BITS-1:0] io_processor_addr,
   input wire logic io_processor_grant,
   input wire logic io_processor_done,
   input wire logic parity_error,
   input wire logic program_interrupt_request,
   input wire logic halt_request
);
   import core_mem_pkg::*;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   // Full cycle lengths, counted from the sample where grant first shows
   sequence plain_end(g);
      ##79 g ##1 !g;
   endsequence
   sequence parity_end(g);
      ##109 g ##1 !g;
   endsequence

   grant_exclusive_a: assert property (!(cpu_grant && io_processor_grant))
      else $error("both ports granted together");
   cpu_access_a: assert property ($rose(cpu_grant) |-> ##40 cpu_done)
      else $error("cpu word not ready after access time");
   io_access_a: assert property ($rose(io_processor_grant) |-> ##40 io_processor_done)
      else $error("io word not ready after access time");
   plain_cycle_a: assert property ($rose(cpu_grant) && !parity_fitted |-> plain_end(cpu_grant))
      else $error("plain cycle has wrong length");
   parity_cycle_a: assert property ($rose(io_processor_grant) && parity_fitted |-> parity_end(io_processor_grant))
      else $error("parity cycle has wrong length");
   io_first_a: assert property (!cpu_grant && !io_processor_grant && cpu_req && io_processor_req
      && !io_processor_addr[17] && !cpu_trap |=> !cpu_grant)
      else $error("cpu granted over a pending io request");
   trap_pulse_a: assert property ($rose(cpu_req) && cpu_addr[17] && protect_fitted && !io_processor_req
      && !cpu_grant && !io_processor_grant |=> cpu_trap ##1 !cpu_trap)
      else $error("illegal address not trapped");
   stall_hold_a: assert property (cpu_req && cpu_addr[17] && !protect_fitted
      |=> !$rose(cpu_grant) && !cpu_trap && !cpu_done)
      else $error("illegal address answered");
   alarm_cause_a: assert property (parity_error |-> parity_fitted && (cpu_done || io_processor_done))
      else $error("parity alarm without a parity read");
   alarm_route_a: assert property (parity_error && !halt_on_parity && !use_priority_interrupt
      |=> program_interrupt_request)
      else $error("alarm did not request program interrupt");
   halt_route_a: assert property (parity_error && halt_on_parity |=> halt_request)
      else $error("alarm did not request halt");
   // A sticky flag may only drop because software cleared it
   alarm_hold_a: assert property ($fell(program_interrupt_request) |-> $past(alarm_clear))
      else $error("alarm flag dropped by itself");
endmodule // core_memory_bank_port_props

bind core_memory_bank_port core_memory_bank_port_props props (.*);

// ===== test/mem_requester.sv
/*
 Partner model of one requester on the shared memory bus.
 Assumes the bench pulses go for one cycle while the model is idle.
*/
`timescale 1ns/10ps
module mem_requester (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic go,
   input wire logic cmd_write,
   input wire logic [core_mem_pkg::ADDR_BITS-1:0] cmd_addr,
   input wire logic [core_mem_pkg::WORD_BITS-1:0] cmd_wdata,
   input wire logic done,
   input wire logic trap,
   output logic req,
   output logic write,
   output logic [core_mem_pkg::ADDR_BITS-1:0] addr,
   output logic [core_mem_pkg::WORD_BITS-1:0] wdata
);
   import core_mem_pkg::*;
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         req <= 1'h0;
         write <= 1'h0;
         addr <= '0;
         wdata <= '0;
      end else if (go && !req) begin
         req <= 1'h1;
         write <= cmd_write;
         addr <= cmd_addr;
         wdata <= cmd_wdata;
      end else if (req && (done || trap)) begin
         // Released lines flip so a stale word can never pass for a live one
         req <= 1'h0;
         addr <= ~addr;
         wdata <= ~wdata;
      end
   end
endmodule // mem_requester

// ===== test/tb.sv
/*
 Self-checking bench for the memory port switch.
 Both requesters are partner models; one 100 MHz clock, fixed stimulus.
*/
`timescale 1ns/10ps
module tb;
   import core_mem_pkg::*;
   logic sys_clk, reset_n, parity_fitted, protect_fitted, mux_fitted;
   logic halt_on_parity, use_priority_interrupt, alarm_clear;
   logic [BANK_SEL_BITS-1:0] cpu_base_bank, io_base_bank;
   logic cpu_req, cpu_write, cpu_grant, cpu_done, cpu_trap;
   logic io_processor_req, io_processor_write, io_processor_grant, io_processor_done;
   logic io_processor_trap, parity_error, program_interrupt_request;
   logic priority_interrupt_request, halt_request;
   logic [ADDR_BITS-1:0] cpu_addr, io_processor_addr, a_cmd;
   logic [WORD_BITS-1:0] cpu_wdata, cpu_rdata, io_processor_wdata, io_processor_rdata, d_cmd;
   logic go_c, go_i, wr_c, wr_i, seen_trap, seen_perr, seen_grant, first_io;
   logic seen_io_trap, expect_hang;
   logic [17:0] addr_tbl [7] = '{18'h00000, 18'h00fff, 18'h01000, 18'h01fff, 18'h02000,
      18'h07fff, 18'h06abc};
   int n_mismatch = 0;
   int check_count = 0;

   core_memory_bank_port dut (.*);
   mem_requester cpu_side (.sys_clk(sys_clk), .reset_n(reset_n), .go(go_c), .cmd_write(wr_c),
      .cmd_addr(a_cmd), .cmd_wdata(d_cmd), .done(cpu_done), .trap(cpu_trap), .req(cpu_req),
      .write(cpu_write), .addr(cpu_addr), .wdata(cpu_wdata));
   mem_requester io_side (.sys_clk(sys_clk), .reset_n(reset_n), .go(go_i), .cmd_write(wr_i),
      .cmd_addr(a_cmd), .cmd_wdata(d_cmd), .done(io_processor_done), .trap(io_processor_trap),
      .req(io_processor_req), .write(io_processor_write), .addr(io_processor_addr),
      .wdata(io_processor_wdata));

   initial begin
      sys_clk = 1'h0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Options bits: parity, protect, multiplexer
   task automatic set_cfg(input logic [2:0] o);
      @(posedge sys_clk);
      {parity_fitted, protect_fitted, mux_fitted} <= o;
   endtask

   // Mode bits: cpu go, io go, cpu write, io write; waits out any running cycle first
   task automatic run(input logic [3:0] m, input logic [17:0] a, input logic [17:0] d,
      input int lim);
      for (int n = 0; n < 200 && (cpu_grant || io_processor_grant); n++) begin
         @(posedge sys_clk);
         #1;
      end
      @(posedge sys_clk);
      {go_c, go_i, wr_c, wr_i} <= m;
      a_cmd <= a;
      d_cmd <= d;
      {seen_trap, seen_io_trap, seen_perr, seen_grant, first_io} = 5'h00;
      for (int n = 0; n < lim; n++) begin
         @(posedge sys_clk);
         {go_c, go_i} <= 2'h0;
         #1;
         if (!seen_grant && (cpu_grant || io_processor_grant)) begin
            first_io = io_processor_grant && !cpu_grant;
         end
         seen_grant |= cpu_grant || io_processor_grant;
         seen_trap |= cpu_trap;
         seen_io_trap |= io_processor_trap;
         seen_perr |= parity_error;
         if (!cpu_req && !io_processor_req) begin
            return;
         end
      end
      // Running out of cycles means a request was never served
      chk(expect_hang, 1'h1);
   endtask

   task automatic s_store;
      set_cfg(3'h0);
      foreach (addr_tbl[k]) begin
         run(4'ha, addr_tbl[k], addr_tbl[k] ^ 18'h2a5a5, 200);
      end
      // Read back only after all writes, so a lost page or bank bit shows as aliasing
      foreach (addr_tbl[k]) begin
         run(4'h4, addr_tbl[k], 18'h00000, 200);
         chk(io_processor_rdata, addr_tbl[k] ^ 18'h2a5a5);
         chk(seen_perr, 1'h0);
      end
   endtask

   task automatic s_prio;
      run(4'hd, 18'h03210, 18'h1c3c3, 300);
      chk(first_io, 1'h1);
      chk(cpu_rdata, 18'h1c3c3);
   endtask

   task automatic s_parity;
      set_cfg(3'h4);
      run(4'ha, 18'h04444, 18'h3ffff, 300);
      run(4'h4, 18'h04444, 18'h00000, 300);
      chk(io_processor_rdata, 18'h3ffff);
      chk(seen_perr, 1'h0);
      set_cfg(3'h0);
      run(4'ha, 18'h05555, 18'h00000, 300);
      for (int r = 0; r < 3; r++) begin
         @(posedge sys_clk);
         halt_on_parity <= (r == 2);
         use_priority_interrupt <= (r == 1);
         alarm_clear <= 1'h1;
         set_cfg(3'h4);
         alarm_clear <= 1'h0;
         run(4'h4, 18'h05555, 18'h00000, 300);
         chk(seen_perr, 1'h1);
         chk({halt_request, priority_interrupt_request, program_interrupt_request}, 3'h1 << r);
      end
      set_cfg(3'h0);
      run(4'h4, 18'h05555, 18'h00000, 300);
      chk(seen_perr, 1'h0);
      chk(io_processor_rdata, 18'h00000);
   endtask

   task automatic s_mux;
      set_cfg(3'h1);
      run(4'ha, 18'h00123, 18'h15a5a, 200);
      run(4'h4, 18'h1e123, 18'h00000, 200);
      chk(io_processor_rdata, 18'h15a5a);
      set_cfg(3'h0);
      run(4'h8, 18'h02123, 18'h00000, 200);
      chk(cpu_rdata, 18'h15a5a);
   endtask

   task automatic s_trap;
      set_cfg(3'h2);
      run(4'h8, 18'h20000, 18'h00000, 50);
      chk(seen_trap, 1'h1);
      chk(seen_grant, 1'h0);
      run(4'h4, 18'h3ffff, 18'h00000, 50);
      chk(seen_io_trap, 1'h1);
      set_cfg(3'h0);
      expect_hang = 1'h1;
      // An unanswered request only clears by reset, so each hang ends in one
      for (int k = 0; k < 2; k++) begin
         run(4'h8, k ? 18'h08000 : 18'h20000, 18'h00000, 100);
         chk(cpu_req, 1'h1);
         chk(seen_grant, 1'h0);
         @(posedge sys_clk);
         reset_n <= 1'h0;
         repeat (2) @(posedge sys_clk);
         reset_n <= 1'h1;
      end
      expect_hang = 1'h0;
   endtask

   initial begin
      reset_n = 1'h0;
      {parity_fitted, protect_fitted, mux_fitted, halt_on_parity} = 4'h0;
      {go_c, go_i, wr_c, wr_i, alarm_clear, use_priority_interrupt} = 6'h00;
      a_cmd = 18'h00000;
      d_cmd = 18'h00000;
      cpu_base_bank = 4'h1;
      io_base_bank = 4'h2;
      expect_hang = 1'h0;
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'h1;
      s_store;
      s_prio;
      s_parity;
      s_mux;
      s_trap;
      close_out;
   end

   // Whole run needs well under 10000 cycles
   initial begin
      #300000;
      n_mismatch++;
      close_out;
   end
endmodule // tb
